// [core/iarb_top.sv]
// input amp ramp, extra gain, click guard and dsp bypass register group
// assumes the control port decoder on the same clock delivers one-cycle write/read strobes
// Operation
// - ramp_duration_sel picks a gain ramp of 21.5 ms (00), 42.5 ms (01) or 85 ms (10).
// - ramp_off bit n makes amplifier n jump straight to its gain, ignoring the duration.
// - extra_gain adds +10 dB over the base gain, giving -2 dB to +45.25 dB in all.
// - extra_gain bit n boosts amplifier n only; cleared, only the base code applies.
// - bits 5 and 4 disable click suppression on outputs 1 and 0 and reset to 1.
// - bits 3 to 0 disable click suppression on inputs 3 to 0, reset to 1, and 0 enables it.
// - bypass_route 00 no bypass, 01 channel 0, 10 channel 1, 11 both channels.
// - bypass_vol0 sets converter 0 volume during bypass and resets to zero.
// - bypass_vol1 sets converter 1 volume during bypass and resets to zero.
// - the six-bit base code spans -12 dB to +35.25 dB in 0.75 dB steps, 0 dB at 010000.
// - while an amplifier is silenced its base code is ignored; silence resets set.
`timescale 1ns/1ps
`include "iarb_defs.svh"
module iarb_top #(
	parameter int RAMP_CYC_00 = int'(`IARB_RAMP_MS_00 * 1.0e6 / `IARB_CLK_NS),
	parameter int RAMP_CYC_01 = int'(`IARB_RAMP_MS_01 * 1.0e6 / `IARB_CLK_NS),
	parameter int RAMP_CYC_10 = int'(`IARB_RAMP_MS_10 * 1.0e6 / `IARB_CLK_NS)
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control port register access
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [`IARB_ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// base gain and silence from the amplifier control registers
	input wire logic [23:0] amp_gain_code_i,
	input wire logic [3:0] amp_silence_i,
	// amplifier drive
	output logic [23:0] amp_gain_o,
	output logic [3:0] amp_silence_o,
	output logic [3:0] amp_extra_gain_o,
	output logic [3:0] amp_ramping_o,
	// click suppression controls
	output logic [1:0] out_click_guard_off_o,
	output logic [3:0] in_click_guard_off_o,
	// bypass mixer
	output logic [1:0] bypass_en_o,
	output logic [7:0] bypass_vol0_o,
	output logic [7:0] bypass_vol1_o
);
	// per-step intervals: a full sweep of all codes takes the selected duration
	localparam logic [21:0] STEP_00 = 22'(RAMP_CYC_00 / `IARB_GAIN_STEPS);
	localparam logic [21:0] STEP_01 = 22'(RAMP_CYC_01 / `IARB_GAIN_STEPS);
	localparam logic [21:0] STEP_10 = 22'(RAMP_CYC_10 / `IARB_GAIN_STEPS);

	logic [5:0] ramp_ctrl_reg, ramp_ctrl_next;
	logic [3:0] extra_gain_reg, extra_gain_next;
	logic [5:0] click_ctrl_reg, click_ctrl_next;
	logic [1:0] route_reg, route_next;
	logic [7:0] vol0_reg, vol0_next;
	logic [7:0] vol1_reg, vol1_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [21:0] step_cyc;
	iarb_pkg::iarb_ramp_sel_t ramp_sel;

	// register writes; only defined bits are stored
	always_comb begin
		ramp_ctrl_next = ramp_ctrl_reg;
		extra_gain_next = extra_gain_reg;
		click_ctrl_next = click_ctrl_reg;
		route_next = route_reg;
		vol0_next = vol0_reg;
		vol1_next = vol1_reg;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`IARB_OFS_RAMP_CTRL: ramp_ctrl_next = reg_wdata_i[`IARB_RAMP_SEL_HI:0];
				`IARB_OFS_EXTRA_GAIN: extra_gain_next = reg_wdata_i[`IARB_EXTRA_HI:0];
				`IARB_OFS_CLICK_CTRL: click_ctrl_next = reg_wdata_i[`IARB_OUT_GUARD_HI:0];
				`IARB_OFS_ROUTE_SEL: route_next = reg_wdata_i[`IARB_ROUTE_HI:0];
				`IARB_OFS_VOL_CH0: vol0_next = reg_wdata_i;
				`IARB_OFS_VOL_CH1: vol1_next = reg_wdata_i;
				default: begin
				end
			endcase
		end
	end

	// register reads, one cycle after the strobe; unmapped addresses read zero
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = reg_rd_i;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`IARB_OFS_RAMP_CTRL: rdata_next = {2'h0, ramp_ctrl_reg};
				`IARB_OFS_EXTRA_GAIN: rdata_next = {4'h0, extra_gain_reg};
				`IARB_OFS_CLICK_CTRL: rdata_next = {2'h0, click_ctrl_reg};
				`IARB_OFS_ROUTE_SEL: rdata_next = {6'h00, route_reg};
				`IARB_OFS_VOL_CH0: rdata_next = vol0_reg;
				`IARB_OFS_VOL_CH1: rdata_next = vol1_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ramp_ctrl_reg <= 6'(`IARB_RST_RAMP_CTRL);
			extra_gain_reg <= 4'(`IARB_RST_EXTRA_GAIN);
			click_ctrl_reg <= 6'(`IARB_RST_CLICK_CTRL);
			route_reg <= 2'(`IARB_RST_ROUTE_SEL);
			vol0_reg <= `IARB_RST_VOL;
			vol1_reg <= `IARB_RST_VOL;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			ramp_ctrl_reg <= ramp_ctrl_next;
			extra_gain_reg <= extra_gain_next;
			click_ctrl_reg <= click_ctrl_next;
			route_reg <= route_next;
			vol0_reg <= vol0_next;
			vol1_reg <= vol1_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// duration select to per-step interval; the unlisted code 11 takes the longest ramp
	assign ramp_sel = iarb_pkg::iarb_ramp_sel_t'(ramp_ctrl_reg[`IARB_RAMP_SEL_HI:`IARB_RAMP_SEL_LO]);
	always_comb begin
		case (ramp_sel)
			iarb_pkg::IARB_RAMP_21: step_cyc = STEP_00;
			iarb_pkg::IARB_RAMP_42: step_cyc = STEP_01;
			iarb_pkg::IARB_RAMP_85: step_cyc = STEP_10;
			default: step_cyc = STEP_10;
		endcase
	end

	iarb_amp_if amp_if [4] ();

	genvar n;
	generate
		for (n = 0; n < 4; n++) begin : g_amp
			assign amp_if[n].target_code = amp_gain_code_i[6*n +: 6];
			assign amp_if[n].silence = amp_silence_i[n];
			assign amp_if[n].ramp_off = ramp_ctrl_reg[n];
			assign amp_if[n].extra_gain = extra_gain_reg[n];
			assign amp_if[n].step_cyc = step_cyc;
			iarb_ramp u_ramp (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.amp(amp_if[n])
			);
			assign amp_gain_o[6*n +: 6] = amp_if[n].gain_code;
			assign amp_silence_o[n] = amp_if[n].silenced;
			assign amp_extra_gain_o[n] = amp_if[n].boosted;
			assign amp_ramping_o[n] = amp_if[n].ramping;
		end
	endgenerate

	iarb_bypass u_bypass (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.route_i(iarb_pkg::iarb_route_t'(route_reg)),
		.vol0_i(vol0_reg),
		.vol1_i(vol1_reg),
		.bypass_en_o(bypass_en_o),
		.bypass_vol0_o(bypass_vol0_o),
		.bypass_vol1_o(bypass_vol1_o)
	);

	assign out_click_guard_off_o = click_ctrl_reg[`IARB_OUT_GUARD_HI:`IARB_OUT_GUARD_LO];
	assign in_click_guard_off_o = click_ctrl_reg[`IARB_IN_GUARD_HI:0];
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
endmodule // iarb_top

// [core/iarb_defs.svh]
// offsets, field positions, reset values and timing figures of the input amp ramp / bypass register group
// assumes a 100 MHz core clock and 16-bit register addresses from the control port
`ifndef IARB_DEFS_SVH
`define IARB_DEFS_SVH

`define IARB_ADDR_W 16
`define IARB_OFS_RAMP_CTRL 16'h0027
`define IARB_OFS_EXTRA_GAIN 16'h0028
`define IARB_OFS_CLICK_CTRL 16'h0029
`define IARB_OFS_ROUTE_SEL 16'h002a
`define IARB_OFS_VOL_CH0 16'h002b
`define IARB_OFS_VOL_CH1 16'h002c

`define IARB_RST_RAMP_CTRL 8'h00
`define IARB_RST_EXTRA_GAIN 8'h00
`define IARB_RST_CLICK_CTRL 8'h3f
`define IARB_RST_ROUTE_SEL 8'h00
`define IARB_RST_VOL 8'h00

`define IARB_RAMP_SEL_HI 5
`define IARB_RAMP_SEL_LO 4
`define IARB_RAMP_OFF_HI 3
`define IARB_EXTRA_HI 3
`define IARB_OUT_GUARD_HI 5
`define IARB_OUT_GUARD_LO 4
`define IARB_IN_GUARD_HI 3
`define IARB_ROUTE_HI 1

`define IARB_CLK_NS 10.0
`define IARB_RAMP_MS_00 21.5
`define IARB_RAMP_MS_01 42.5
`define IARB_RAMP_MS_10 85.0
`define IARB_GAIN_STEPS 63
`define IARB_CODE_MAX 6'h3f

`endif

// [core/iarb_pkg.sv]
// types shared by the input amp ramp / bypass register group
// constants live in iarb_defs.svh
package iarb_pkg;
	typedef enum logic [1:0] {
		IARB_RAMP_21 = 2'b00,
		IARB_RAMP_42 = 2'b01,
		IARB_RAMP_85 = 2'b10,
		IARB_RAMP_RSV = 2'b11
	} iarb_ramp_sel_t;

	typedef enum logic [1:0] {
		IARB_ROUTE_NONE = 2'b00,
		IARB_ROUTE_CH0 = 2'b01,
		IARB_ROUTE_CH1 = 2'b10,
		IARB_ROUTE_BOTH = 2'b11
	} iarb_route_t;

	typedef enum logic [0:0] {
		IARB_ST_IDLE = 1'b0,
		IARB_ST_RAMP = 1'b1
	} iarb_ramp_st_t;
endpackage

// [core/iarb_amp_if.sv]
// per-amplifier bundle between the register group and one gain ramp unit
// single clock domain, no clocking
`timescale 1ns/1ps
interface iarb_amp_if;
	logic [5:0] target_code;
	logic silence;
	logic ramp_off;
	logic extra_gain;
	logic [21:0] step_cyc;
	logic [5:0] gain_code;
	logic silenced;
	logic boosted;
	logic ramping;

	modport regs (output target_code, silence, ramp_off, extra_gain, step_cyc,
		input gain_code, silenced, boosted, ramping);
	modport ramp (input target_code, silence, ramp_off, extra_gain, step_cyc,
		output gain_code, silenced, boosted, ramping);
endinterface

// [core/iarb_ramp.sv]
// gain ramp for one input amplifier: walks the applied code one step at a time toward the target
// assumes target and controls come from logic on the same clock
`timescale 1ns/1ps
`include "iarb_defs.svh"
module iarb_ramp (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control and result
	iarb_amp_if.ramp amp
);
	iarb_pkg::iarb_ramp_st_t st_reg, st_next;
	logic [5:0] code_reg, code_next;
	logic [21:0] cnt_reg, cnt_next;
	logic sil_reg, sil_next;
	logic boost_reg, boost_next;

	always_comb begin
		st_next = st_reg;
		code_next = code_reg;
		cnt_next = cnt_reg;
		sil_next = amp.silence;
		boost_next = amp.extra_gain;
		if (amp.silence) begin
			// muted: the base code is not applied, hold where we are
			st_next = iarb_pkg::IARB_ST_IDLE;
			cnt_next = '0;
		end else if (amp.ramp_off) begin
			code_next = amp.target_code;
			st_next = iarb_pkg::IARB_ST_IDLE;
			cnt_next = '0;
		end else begin
			case (st_reg)
				iarb_pkg::IARB_ST_IDLE: begin
					if (code_reg != amp.target_code) begin
						st_next = iarb_pkg::IARB_ST_RAMP;
						cnt_next = '0;
					end
				end
				iarb_pkg::IARB_ST_RAMP: begin
					if (code_reg == amp.target_code) begin
						st_next = iarb_pkg::IARB_ST_IDLE;
					end else if (cnt_reg + 22'h000001 >= amp.step_cyc) begin
						cnt_next = '0;
						code_next = (code_reg < amp.target_code) ? code_reg + 6'h01 : code_reg - 6'h01;
					end else begin
						cnt_next = cnt_reg + 22'h000001;
					end
				end
				default: begin
					st_next = iarb_pkg::IARB_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= iarb_pkg::IARB_ST_IDLE;
			code_reg <= 6'h00;
			cnt_reg <= 22'h000000;
			sil_reg <= 1'b1;
			boost_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			code_reg <= code_next;
			cnt_reg <= cnt_next;
			sil_reg <= sil_next;
			boost_reg <= boost_next;
		end
	end

	assign amp.gain_code = code_reg;
	assign amp.silenced = sil_reg;
	assign amp.boosted = boost_reg;
	assign amp.ramping = (st_reg == iarb_pkg::IARB_ST_RAMP);
endmodule // iarb_ramp

// [core/iarb_bypass.sv]
// dsp bypass route decode and bypass volume outputs for the two output converters
// assumes route and volumes come from registers on the same clock
`timescale 1ns/1ps
module iarb_bypass (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// settings
	input wire iarb_pkg::iarb_route_t route_i,
	input wire logic [7:0] vol0_i,
	input wire logic [7:0] vol1_i,
	// to the output mixer
	output logic [1:0] bypass_en_o,
	output logic [7:0] bypass_vol0_o,
	output logic [7:0] bypass_vol1_o
);
	logic [1:0] en_reg, en_next;
	logic [7:0] vol0_reg, vol0_next;
	logic [7:0] vol1_reg, vol1_next;

	always_comb begin
		case (route_i)
			iarb_pkg::IARB_ROUTE_NONE: en_next = 2'h0;
			iarb_pkg::IARB_ROUTE_CH0: en_next = 2'h1;
			iarb_pkg::IARB_ROUTE_CH1: en_next = 2'h2;
			iarb_pkg::IARB_ROUTE_BOTH: en_next = 2'h3;
			default: en_next = 2'h0;
		endcase
		vol0_next = vol0_i;
		vol1_next = vol1_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_reg <= 2'h0;
			vol0_reg <= 8'h00;
			vol1_reg <= 8'h00;
		end else begin
			en_reg <= en_next;
			vol0_reg <= vol0_next;
			vol1_reg <= vol1_next;
		end
	end

	assign bypass_en_o = en_reg;
	assign bypass_vol0_o = vol0_reg;
	assign bypass_vol1_o = vol1_reg;
endmodule // iarb_bypass

// [bench/iarb_monitor.sv]
// port checks for the input amp ramp / bypass register group
// bound to iarb_top by the bench; one clock, async high reset
`timescale 1ns/1ps
module iarb_monitor (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rvalid_o,
	// amplifier and mixer side
	input wire logic [3:0] amp_silence_i,
	input wire logic [23:0] amp_gain_o,
	input wire logic [3:0] amp_extra_gain_o,
	input wire logic [3:0] amp_ramping_o,
	input wire logic [1:0] out_click_guard_off_o,
	input wire logic [3:0] in_click_guard_off_o,
	input wire logic [1:0] bypass_en_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	in_guard_a: assert property (reg_wr_i && reg_addr_i == 16'h0029 |=>
		in_click_guard_off_o == $past(reg_wdata_i[3:0])) else $error("input guard wrong");
	out_guard_a: assert property (reg_wr_i && reg_addr_i == 16'h0029 |=>
		out_click_guard_off_o == $past(reg_wdata_i[5:4])) else $error("output guard wrong");
	extra_gain_a: assert property (reg_wr_i && reg_addr_i == 16'h0028 ##1 !(reg_wr_i && reg_addr_i == 16'h0028)
		|=> amp_extra_gain_o == $past(reg_wdata_i[3:0], 2)) else $error("boost wrong");
	route_decode_a: assert property (reg_wr_i && reg_addr_i == 16'h002a ##1 !(reg_wr_i && reg_addr_i == 16'h002a)
		|=> bypass_en_o == $past(reg_wdata_i[1:0], 2)) else $error("route wrong");
	mute_hold_a: assert property (amp_silence_i[0] ##1 amp_silence_i[0] |=>
		$stable(amp_gain_o[5:0]) && !amp_ramping_o[0]) else $error("muted gain moved");
	ramp_start_a: assert property ($rose(amp_ramping_o[0]) |-> $stable(amp_gain_o[5:0])[*8])
		else $error("ramp stepped early");
	step_size_a: assert property ($past(amp_ramping_o[0]) && amp_ramping_o[0] && $changed(amp_gain_o[5:0]) |->
		(amp_gain_o[5:0] - $past(amp_gain_o[5:0])) == 6'h01 || ($past(amp_gain_o[5:0]) - amp_gain_o[5:0]) == 6'h01)
		else $error("ramp step not one code");
endmodule // iarb_monitor

// [bench/input_amp_ramp_bypass_regs_test.sv]
// self-checking bench for the input amp ramp / bypass register group
// drives iarb_top directly with short ramp parameters; checker bound at the foot
`timescale 1ns/1ps
module input_amp_ramp_bypass_regs_test;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o, bypass_vol0_o, bypass_vol1_o;
	logic reg_rvalid_o;
	logic [23:0] amp_gain_code_i = 24'h000000;
	logic [3:0] amp_silence_i = 4'hf;
	logic [23:0] amp_gain_o;
	logic [3:0] amp_silence_o, amp_extra_gain_o, amp_ramping_o, in_click_guard_off_o;
	logic [1:0] out_click_guard_off_o, bypass_en_o;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] seed = 32'habc3;
	logic [7:0] mdl [0:5] = '{8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk [0:5] = '{8'h3f, 8'h0f, 8'h3f, 8'h03, 8'hff, 8'hff};

	iarb_top #(.RAMP_CYC_00(630), .RAMP_CYC_01(1260), .RAMP_CYC_10(2520)) u_iarb_top (.core_clk_i, .rst_i,
		.reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .amp_gain_code_i,
		.amp_silence_i, .amp_gain_o, .amp_silence_o, .amp_extra_gain_o, .amp_ramping_o, .out_click_guard_off_o,
		.in_click_guard_off_o, .bypass_en_o, .bypass_vol0_o, .bypass_vol1_o);

	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches = mismatches + 1;
			results();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge core_clk_i);
		reg_wr_i = 1'b0;
		if (a >= 16'h0027 && a <= 16'h002c)
			mdl[a - 16'h0027] = d & msk[a - 16'h0027];
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge core_clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge core_clk_i);
		reg_rd_i = 1'b0;
		chk(reg_rvalid_o, 1'b1);
		chk(reg_rdata_o, (a >= 16'h0027 && a <= 16'h002c) ? mdl[a - 16'h0027] : 8'h00);
	endtask
	task automatic outs();
		chk(in_click_guard_off_o, mdl[2][3:0]);
		chk(out_click_guard_off_o, mdl[2][5:4]);
		chk(amp_extra_gain_o, mdl[1][3:0]);
		chk(bypass_en_o, mdl[3][1:0]);
		chk(bypass_vol0_o, mdl[4]);
		chk(bypass_vol1_o, mdl[5]);
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		int n;
		int st;
		logic [5:0] t;
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_i = 1'b0;
		chk(amp_silence_o, 4'hf);
		outs();
		for (int a = 16'h0027; a <= 16'h002d; a++)
			rd(a[15:0]);
		repeat (60) begin
			seed = xs(seed);
			wr(16'h0027 + seed[10:8] % 3'd7, seed[7:0]);
			rd(16'h0027 + seed[18:16] % 3'd7);
			outs();
		end
		// amp0 ramps, amp1 jumps with its ramp turned off
		amp_silence_i = 4'h0;
		t = 6'h00;
		for (int k = 0; k < 4; k++) begin
			st = (k == 0) ? 10 : (k == 1) ? 20 : 40;
			wr(16'h0027, {2'b00, k[1:0], 4'b0010});
			t = t + 6'h02;
			amp_gain_code_i = {12'h000, 6'h3f - t, t};
			n = 0;
			while (amp_gain_o[5:0] !== t && n < 200) begin
				@(posedge core_clk_i);
				#1;
				n++;
			end
			chk(n, 1 + 2 * st);
			chk(amp_ramping_o, 4'h1);
			chk(amp_gain_o[11:6], 6'h3f - t);
		end
		@(negedge core_clk_i);
		amp_silence_i = 4'h1;
		amp_gain_code_i[5:0] = 6'h00;
		repeat (30) @(negedge core_clk_i);
		chk(amp_gain_o[5:0], t);
		chk(amp_silence_o, 4'h1);
		chk(amp_ramping_o, 4'h0);
		results();
	end
endmodule // input_amp_ramp_bypass_regs_test

bind iarb_top iarb_monitor u_iarb_monitor (.core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
	.reg_rvalid_o, .amp_silence_i, .amp_gain_o, .amp_extra_gain_o, .amp_ramping_o, .out_click_guard_off_o,
	.in_click_guard_off_o, .bypass_en_o);
